// ---- pkg/eip_map.svh ----
// Constants for the external interrupt pin block.
`ifndef EIP_MAP_SVH
`define EIP_MAP_SVH
`define EIP_NUM_PINS 5
`define EIP_PIN_ZERO 0
`define EIP_PIN_ONE 1
`define EIP_PIN_TWO 2
`define EIP_PIN_THREE 3
`define EIP_PIN_FOUR 4
`define EIP_PIN_RESET 1'b1
`define EIP_WAKE_MASK 5'h1e
`define EIP_SELECTABLE_MASK 5'h03
`endif

// ---- pkg/eip_pkg.sv ----
// Types for the external interrupt pin block.
`default_nettype none
package eip_pkg;
	typedef enum logic {
		EIP_BOTH_EDGES,
		EIP_FALLING_ONLY
	} eip_edge_mode_type;
endpackage : eip_pkg
`default_nettype wire

// ---- tb/eip_monitor.sv ----
// Assertions on the external interrupt pin block.
`timescale 1ns/1ps
`default_nettype none
module eip_monitor (
	input wire logic       mclk,
	input wire logic       nrst,
	input wire logic       powerDown,
	input wire logic       wakeUp,
	input wire logic       extIrqZero,
	input wire logic       extIrqOne,
	input wire logic       extIrqTwo,
	input wire logic       extIrqThree,
	input wire logic       extIrqFour,
	input wire logic       irqZeroEdgeSelect,
	input wire logic       irqOneEdgeSelect,
	input wire logic [4:0] irqPending
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	// The mode and power-down are looked at as the edge is decoded.
	sequence zeroRise; $rose(extIrqZero) ##2 !irqZeroEdgeSelect; endsequence
	sequence oneRise; $rose(extIrqOne) ##2 !irqOneEdgeSelect; endsequence
	sequence oneFallPd; $fell(extIrqOne) ##2 powerDown; endsequence
	sequence lowFallPd;
		($fell(extIrqTwo) || $fell(extIrqThree) || $fell(extIrqFour))
		##2 powerDown;
	endsequence
	zero_fall_a: assert property (
		$fell(extIrqZero) |-> ##3 irqPending[0]) else $error("pin zero fall");
	zero_rise_a: assert property (
		zeroRise |-> ##1 irqPending[0]) else $error("pin zero rise");
	one_fall_a: assert property (
		$fell(extIrqOne) |-> ##3 irqPending[1]) else $error("pin one fall");
	one_rise_a: assert property (
		oneRise |-> ##1 irqPending[1]) else $error("pin one rise");
	one_wake_a: assert property (
		oneFallPd |-> ##1 wakeUp) else $error("pin one wake");
	two_set_a: assert property (
		$fell(extIrqTwo) |-> ##3 irqPending[2]) else $error("pin two");
	three_set_a: assert property (
		$fell(extIrqThree) |-> ##3 irqPending[3]) else $error("pin three");
	four_cause_a: assert property (
		$rose(irqPending[4]) |-> $past(extIrqFour, 4) && !$past(extIrqFour, 3))
		else $error("pin four");
	low_wake_a: assert property (
		lowFallPd |-> ##1 wakeUp) else $error("wake");
endmodule : eip_monitor
`default_nettype wire

// ---- tb/eip_pin_src.sv ----
// Idle-high external sources that drive the interrupt pins.
`timescale 1ns/1ps
`default_nettype none
module eip_pin_src (
	input  wire logic [4:0] lvl,
	output wire logic [4:0] pins
);
	assign pins = lvl;
endmodule : eip_pin_src
`default_nettype wire

// ---- tb/tb_top.sv ----
// Random pin bench for the external interrupt block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic       mclk = 0, nrst = 0, pd = 0, wake;
	logic [1:0] sel = 0;
	logic [4:0] lvl = 5'h1f, ack = 0, pins, pend, q;
	logic [7:0] lf = 8'h51;
	int         error_cnt = 0, n_checks = 0;
	eip_pin_src u_src (.lvl(lvl), .pins(pins));
	eip_ext_irq u_dut (.mclk(mclk), .nrst(nrst), .extIrqZero(pins[0]),
		.extIrqOne(pins[1]), .extIrqTwo(pins[2]), .extIrqThree(pins[3]),
		.extIrqFour(pins[4]), .irqZeroEdgeSelect(sel[0]), .powerDown(pd),
		.irqOneEdgeSelect(sel[1]), .irqAck(ack), .irqPending(pend), .wakeUp(wake));
	function automatic logic [7:0] nxt(logic [7:0] v);
		return {v[6:0], ^(v & 8'hb8)};
	endfunction : nxt
	function automatic logic [4:0] qual(logic [4:0] o, n, logic [1:0] s);
		return o & ~n | (o ^ n) & {3'h0, ~s};
	endfunction : qual
	task automatic chk(string nm, logic [4:0] s, e);
		n_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("ERROR %s exp %h got %h", nm, e, s);
		end
	endtask : chk
	task conclude;
		if (error_cnt == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : conclude
	initial forever #5 mclk = ~mclk;
	initial begin
		#30000;
		error_cnt++;
		conclude;
	end
	initial begin
		repeat (2) @(posedge mclk);
		nrst <= 1;
		repeat (60) begin
			@(posedge mclk);
			q = qual(lvl, lvl ^ lf[4:0], lf[6:5]);
			lvl <= lvl ^ lf[4:0];
			{pd, sel} <= lf[7:5];
			lf <= nxt(lf);
			repeat (3) @(posedge mclk);
			#1;
			chk("pending", pend, q);
			chk("wake", {4'h0, wake}, {4'h0, pd & |(q & 5'h1e)});
			@(posedge mclk);
			ack <= 5'h1f;
			@(posedge mclk);
			ack <= 5'h00;
			#1;
			chk("cleared", pend, 5'h00);
		end
		// Corner case: an acknowledge in the cycle that sets the flag.
		@(posedge mclk);
		{pd, sel} <= 3'h3;
		lvl <= 5'h1f;
		repeat (4) @(posedge mclk);
		lvl <= 5'h1b;
		repeat (2) @(posedge mclk);
		ack <= 5'h1f;
		@(posedge mclk);
		ack <= 5'h00;
		#1;
		chk("set wins", pend, 5'h04);
		conclude;
	end
endmodule : tb_top
bind eip_ext_irq eip_monitor u_mon (
	.mclk             (mclk),
	.nrst             (nrst),
	.powerDown        (powerDown),
	.wakeUp           (wakeUp),
	.extIrqZero       (extIrqZero),
	.extIrqOne        (extIrqOne),
	.extIrqTwo        (extIrqTwo),
	.extIrqThree      (extIrqThree),
	.extIrqFour       (extIrqFour),
	.irqZeroEdgeSelect(irqZeroEdgeSelect),
	.irqOneEdgeSelect (irqOneEdgeSelect),
	.irqPending       (irqPending)
);
`default_nettype wire

// ---- verilog/eip_ext_irq.sv ----
// Edge detection, pending flags and wake-up for five interrupt pins.
`timescale 1ns/1ps
`default_nettype none
`include "eip_map.svh"
module eip_ext_irq (
	input  wire logic mclk,
	input  wire logic nrst,
	input  wire logic extIrqZero,
	input  wire logic extIrqOne,
	input  wire logic extIrqTwo,
	input  wire logic extIrqThree,
	input  wire logic extIrqFour,
	input  wire logic irqZeroEdgeSelect,
	input  wire logic irqOneEdgeSelect,
	input  wire logic powerDown,
	input  wire logic [4:0] irqAck,
	output var  logic [4:0] irqPending,
	output var  logic wakeUp
);
	// A pin step driven at one clock edge is in the first synchroniser
	// stage after the next edge and in the second one edge later.
	// The edge decode then sees it, and the flag and the wake pulse
	// are loaded at the third edge after the step.
	// A pin must hold a level for at least one clock to be seen.
	// Shorter glitches may be lost; that is the price of sampling
	// asynchronous pins through a synchroniser.

	// Raw pin levels, bit i being pin i.
	logic [4:0] pinVec;
	// Settled level of each pin after the synchroniser.
	logic [4:0] nowVec;
	// Settled level of each pin one clock earlier.
	logic [4:0] prevVec;
	// A high to low step between the last two settled samples.
	logic [4:0] fallEdge;
	// A low to high step between the last two settled samples.
	logic [4:0] riseEdge;
	// Pins whose mode accepts rising edges as well as falling ones.
	logic [4:0] bothMode;
	// Rising edges that the mode of their pin accepts.
	logic [4:0] riseTaken;
	// Edges that raise a request in this cycle.
	logic [4:0] hitVec;
	// Flags that an acknowledge clears in this cycle.
	logic [4:0] clearVec;
	// Flags that stand on into the next cycle.
	logic [4:0] keepVec;
	// Pins that are able to bring the device out of power-down.
	logic [4:0] wakeCapable;
	// Qualifying edges on pins that are able to wake the device.
	logic [4:0] wakeHit;
	logic       anyWakeHit;
	logic [4:0] pendQ;
	logic [4:0] pendD;
	logic       wakeQ;
	logic       wakeD;
	eip_pkg::eip_edge_mode_type modeZero;
	eip_pkg::eip_edge_mode_type modeOne;

	// Gather the pins into one vector so the per-pin logic is a loop.
	assign pinVec[`EIP_PIN_ZERO]  = extIrqZero;
	assign pinVec[`EIP_PIN_ONE]   = extIrqOne;
	assign pinVec[`EIP_PIN_TWO]   = extIrqTwo;
	assign pinVec[`EIP_PIN_THREE] = extIrqThree;
	assign pinVec[`EIP_PIN_FOUR]  = extIrqFour;

	// The select inputs are read as the edge mode of their pin.
	assign modeZero = eip_pkg::eip_edge_mode_type'(irqZeroEdgeSelect);
	assign modeOne  = eip_pkg::eip_edge_mode_type'(irqOneEdgeSelect);

	// Only the two selectable pins may take both edges.
	assign bothMode[`EIP_PIN_ZERO] =
		(modeZero == eip_pkg::EIP_BOTH_EDGES);
	assign bothMode[`EIP_PIN_ONE] =
		(modeOne == eip_pkg::EIP_BOTH_EDGES);
	assign bothMode[`EIP_PIN_TWO]   = 1'b0;
	assign bothMode[`EIP_PIN_THREE] = 1'b0;
	assign bothMode[`EIP_PIN_FOUR]  = 1'b0;

	// Pins one to four wake the device; pin zero never does.
	assign wakeCapable = `EIP_WAKE_MASK;

	genvar gi;
	generate
		for (gi = 0; gi < `EIP_NUM_PINS; gi++) begin : g_pin
			// The synchroniser resets to the idle level, so a pin held
			// high through reset shows no edge at release.
			eip_pin_sync u_sync (
				.mclk    (mclk),
				.nrst    (nrst),
				.pinIn   (pinVec[gi]),
				.syncNow (nowVec[gi]),
				.syncPrev(prevVec[gi])
			);

			// Edges are found by comparing consecutive settled samples.
			assign fallEdge[gi] = prevVec[gi] & ~nowVec[gi];
			assign riseEdge[gi] = ~prevVec[gi] & nowVec[gi];

			// Rising edges count only on a pin in both-edges mode.
			assign riseTaken[gi] = riseEdge[gi] & bothMode[gi];

			// Falling edges count on every pin.
			assign hitVec[gi] = fallEdge[gi] | riseTaken[gi];

			// An acknowledge clears a flag only when no new edge lands.
			assign clearVec[gi] = irqAck[gi] & ~hitVec[gi];
			assign keepVec[gi]  = pendQ[gi] & ~clearVec[gi];

			// A new edge wins over an acknowledge in the same cycle.
			assign pendD[gi] = keepVec[gi] | hitVec[gi];

			// Only a qualifying edge on a capable pin may wake.
			assign wakeHit[gi] = hitVec[gi] & wakeCapable[gi];
		end
	endgenerate

	// Waking needs the device to be in power-down as the edge lands.
	assign anyWakeHit = |wakeHit;
	assign wakeD      = powerDown & anyWakeHit;

	// Pending flags are sticky until acknowledged.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pendQ <= 5'h00;
		end else begin
			pendQ <= pendD;
		end
	end

	// The wake pulse lasts one clock for each cycle with a qualifying edge on a capable pin during power-down.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			wakeQ <= 1'b0;
		end else begin
			wakeQ <= wakeD;
		end
	end

	assign irqPending = pendQ;
	assign wakeUp     = wakeQ;
endmodule : eip_ext_irq
`default_nettype wire

// ---- verilog/eip_pin_sync.sv ----
// Two-stage synchroniser with a third stage for edge detection.
`timescale 1ns/1ps
`default_nettype none
`include "eip_map.svh"
module eip_pin_sync (
	input  wire logic mclk,
	input  wire logic nrst,
	input  wire logic pinIn,
	output var  logic syncNow,
	output var  logic syncPrev
);
	logic metaQ;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			metaQ    <= `EIP_PIN_RESET;
			syncNow  <= `EIP_PIN_RESET;
			syncPrev <= `EIP_PIN_RESET;
		end else begin
			metaQ    <= pinIn;
			syncNow  <= metaQ;
			syncPrev <= syncNow;
		end
	end
endmodule : eip_pin_sync
`default_nettype wire
